// ### icw_config_port.sv
// I2C slave configuration port with write parity checking.
// Assumes scl and sda come from an I2C master; sda and irq are open drain
// and resolved outside from the enables; fault inputs are asynchronous.
//
// What this block does
// - Interrupt pin is open drain, pulled low while any fault or parity error pends.
// - Each write computes per-register parity into the parity register before comparing.
// - Parity mismatch sets the parity error flag and asserts the interrupt.
// - Two write modes: current writes one register, sequential writes all seven.
// - In a write the device acknowledges the address byte and the first eight data bytes the host writes.
// - First byte holds 7-bit slave address in bits 7..1, direction in bit 0.
// - Third byte: bits 7..5 parity, bit 4 ignored, bits 3..0 register address.
// - Register address field is four bits wide, sixteen locations.
// - Full parity is XOR of all bits; odd and even bit parities as well.
// - Failed current write leaves the target register unchanged.
// - Sequential write compares parity register with host byte; mismatch flags error.
// - Sequential data order: config, control 1, control 2, LED bytes, then parity.
// - Sequential parity per register is full XOR; host bits 6..0 map in order.
// - Failed sequential write leaves all seven writable registers unchanged.
// - Addresses: status 0, config 1, controls 2-3, LEDs 4-7, parity 8.
`timescale 1ns/10ps
`default_nettype none
module icw_config_port import icw_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A
) (
	// Core clock and reset.
	input  wire logic       clock,
	input  wire logic       reset,
	// I2C link.
	input  wire logic       scl,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	// Open-drain interrupt.
	output var  logic       irq_out,
	output var  logic       irq_oe,
	// Fault inputs from the analog side.
	input  wire logic       fault_power_on,
	input  wire logic       fault_overtemp,
	input  wire logic       fault_cq_overload,
	input  wire logic       fault_iq_overload,
	input  wire logic       fault_reg_undervolt,
	// Register contents.
	output var  logic [7:0] config_reg,
	output var  logic [7:0] control1,
	output var  logic [7:0] control2,
	output var  logic [7:0] led1_high,
	output var  logic [7:0] led1_low,
	output var  logic [7:0] led2_high,
	output var  logic [7:0] led2_low,
	output var  logic [7:0] parity_reg,
	output var  logic [7:0] status_reg,
	output var  logic       parity_error_flag
);
	if (SLAVE_ADDR == 7'h00) begin : g_bad_addr
		$error("Slave address zero is the general call address.");
	end

	// ********************************************************************
	// Declarations.
	// ********************************************************************
	logic       link_clear;
	logic       link_rst;
	logic [3:0] bit_cnt;
	logic [3:0] byte_cnt;
	logic [7:0] shift;
	logic       addressed;
	logic       reading;
	logic       nacked;
	logic [7:0] rx_hold;
	logic [3:0] rx_idx;
	logic       rx_tgl;
	logic [7:0] snap_status;
	logic [7:0] snap_parity;
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic       scl_d;
	logic       sda_d;
	logic [2:0] tgl_s;
	logic [NUM_FAULTS-1:0] flt_s1;
	logic [NUM_FAULTS-1:0] flt_s2;
	logic       frame_active;
	logic       got_addr;
	logic       rx_read;
	logic [3:0] rx_count;
	logic [7:0] rx_buf [SEQ_BYTES];
	logic [7:0] regs [NUM_WR_REGS];

	// ********************************************************************
	// Link domain: bit and byte reception on scl.
	// ********************************************************************
	assign link_rst = reset | link_clear;

	wire [7:0] shift_next = {shift[6:0], sda_in};
	wire       byte_done  = bit_cnt == LAST_BIT;
	wire       ack_slot   = bit_cnt == ACK_BIT;
	wire       addr_hit   = shift_next[7:1] == SLAVE_ADDR;
	wire       last_cnt   = byte_cnt == 4'hF;
	wire       pass_byte  = byte_done &&
		(byte_cnt == 4'h0 ? addr_hit : addressed && !reading);

	always_ff @(posedge scl or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt   <= 4'h0;
			byte_cnt  <= 4'h0;
			shift     <= 8'h00;
			addressed <= 1'b0;
			reading   <= 1'b0;
			nacked    <= 1'b0;
		end else begin
			shift <= shift_next;
			if (ack_slot) begin
				bit_cnt  <= 4'h0;
				byte_cnt <= last_cnt ? byte_cnt : byte_cnt + 4'h1;
				nacked   <= nacked | (reading & sda_in);
			end else begin
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (byte_done && byte_cnt == 4'h0) begin
				addressed <= addr_hit;
				reading   <= addr_hit & shift_next[0];
			end
		end
	end

	// Byte hand-over toggles; reset only by the core reset so that a
	// START never fakes an event.
	always_ff @(posedge scl or posedge reset) begin
		if (reset) begin
			rx_hold <= 8'h00;
			rx_idx  <= 4'h0;
			rx_tgl  <= 1'b0;
		end else if (pass_byte) begin
			rx_hold <= shift_next;
			rx_idx  <= byte_cnt;
			rx_tgl  <= ~rx_tgl;
		end
	end

	// ********************************************************************
	// Link domain: acknowledge and read data on the falling edge.
	// ********************************************************************
	wire [7:0] tx_byte = byte_cnt == RD_STATUS ? snap_status :
		byte_cnt == RD_PARITY ? snap_parity : IDLE_BYTE;
	wire [2:0] tx_pos  = 3'h7 - bit_cnt[2:0];
	wire       do_ack  = addressed &&
		(byte_cnt == 4'h0 || (!reading && byte_cnt <= SEQ_BYTES));
	wire       do_tx   = reading && !nacked && byte_cnt != 4'h0;
	wire       next_sda_oe = ack_slot ? do_ack : do_tx && !tx_byte[tx_pos];

	always_ff @(negedge scl or posedge link_rst) begin
		if (link_rst) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe;
		end
	end

	// ********************************************************************
	// Core domain: synchronisers and START/STOP detection.
	// ********************************************************************
	wire [NUM_FAULTS-1:0] flt_in = {fault_power_on, fault_overtemp,
		fault_cq_overload, fault_iq_overload, fault_reg_undervolt};

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			scl_s  <= 2'h3;
			sda_s  <= 2'h3;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
			tgl_s  <= 3'h0;
			flt_s1 <= '0;
			flt_s2 <= '0;
		end else begin
			scl_s  <= {scl_s[0], scl};
			sda_s  <= {sda_s[0], sda_in};
			scl_d  <= scl_s[1];
			sda_d  <= sda_s[1];
			tgl_s  <= {tgl_s[1:0], rx_tgl};
			flt_s1 <= flt_in;
			flt_s2 <= flt_s1;
		end
	end

	wire scl_high  = scl_d & scl_s[1];
	wire start_det = scl_high & sda_d & ~sda_s[1];
	wire stop_det  = scl_high & ~sda_d & sda_s[1];
	wire rx_evt    = tgl_s[2] ^ tgl_s[1];

	// The link counters are held clear from START until scl falls.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			link_clear   <= 1'b0;
			frame_active <= 1'b0;
		end else begin
			link_clear   <= start_det | (link_clear & scl_s[1]);
			frame_active <= start_det | (frame_active & ~stop_det);
		end
	end

	// Read data is frozen for the whole frame, so scl may sample it.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			snap_status <= 8'h00;
			snap_parity <= RST_PARITY;
		end else if (!frame_active) begin
			snap_status <= status_reg;
			snap_parity <= parity_reg;
		end
	end

	// ********************************************************************
	// Core domain: byte collection.
	// ********************************************************************
	wire [2:0] buf_idx = 3'(rx_idx - 4'h1);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			got_addr <= 1'b0;
			rx_read  <= 1'b0;
			rx_count <= 4'h0;
		end else if (start_det) begin
			got_addr <= 1'b0;
			rx_read  <= 1'b0;
			rx_count <= 4'h0;
		end else if (rx_evt && rx_idx == 4'h0) begin
			got_addr <= 1'b1;
			rx_read  <= rx_hold[0];
		end else if (rx_evt) begin
			rx_count <= rx_idx;
		end
	end

	always_ff @(posedge clock) begin
		if (rx_evt && rx_idx != 4'h0 && rx_idx <= SEQ_BYTES) begin
			rx_buf[buf_idx] <= rx_hold;
		end
	end

	// ********************************************************************
	// Core domain: parity evaluation at STOP.
	// ********************************************************************
	wire       wr_end  = stop_det & got_addr & ~rx_read;
	wire       rd_end  = stop_det & got_addr & rx_read;
	wire       cur_end = wr_end && rx_count == CUR_BYTES;
	wire       seq_end = wr_end && rx_count == SEQ_BYTES;
	wire [7:0] cur_data = rx_buf[0];
	wire [7:0] cur_ctl  = rx_buf[1];
	wire [3:0] cur_ra   = cur_ctl[CUR_ADDR_HI:0];
	wire [2:0] cur_host = cur_ctl[CUR_PAR_HI:CUR_PAR_LO];
	wire       cur_full = ^cur_data;
	wire [2:0] cur_calc = {^(cur_data & EVEN_MASK),
		^(cur_data & ODD_MASK), cur_full};
	wire       cur_ok   = cur_calc == cur_host;
	wire       cur_wr   = cur_ra >= ADDR_FIRST_WR &&
		cur_ra <= ADDR_LAST_WR;
	wire [2:0] cur_idx  = 3'(cur_ra - ADDR_FIRST_WR);
	logic [NUM_WR_REGS-1:0] seq_par;
	wire       seq_ok   = seq_par == rx_buf[7][NUM_WR_REGS-1:0];
	wire       wr_fail  = (cur_end & ~cur_ok) | (seq_end & ~seq_ok);
	wire       next_pe  = wr_fail | (parity_error_flag & ~rd_end);
	logic [7:0] next_parity;
	logic [7:0] next_status;

	assign next_status = {flt_s2[4], 1'b0, flt_s2[3], flt_s2[2], flt_s2[1],
		1'b0, flt_s2[0], next_pe};
	assign next_parity[PAR_STATUS] = wr_end ? ^status_reg :
		parity_reg[PAR_STATUS];

	// One parity bit and one writable register per entry.
	for (genvar i = 0; i < NUM_WR_REGS; i++) begin : g_reg
		localparam int PB = NUM_WR_REGS - 1 - i;
		wire [7:0] next_reg = (seq_end && seq_ok) ? rx_buf[i] :
			(cur_end && cur_ok && cur_wr && cur_idx == 3'(i)) ?
			cur_data : regs[i];
		assign seq_par[PB] = ^rx_buf[i];
		assign next_parity[PB] = seq_end ? seq_par[PB] :
			(cur_end && cur_wr && cur_idx == 3'(i)) ? cur_full :
			parity_reg[PB];
		always_ff @(posedge clock or posedge reset) begin
			if (reset) begin
				regs[i] <= i == 0 ? RST_CONFIG : i == 1 ? RST_CTRL1 :
					i == 2 ? RST_CTRL2 : RST_LED;
			end else begin
				regs[i] <= next_reg;
			end
		end
	end

	// ********************************************************************
	// Core domain: status, parity and interrupt.
	// ********************************************************************
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			parity_error_flag <= 1'b0;
			parity_reg        <= RST_PARITY;
			status_reg        <= 8'h00;
			irq_oe            <= 1'b0;
			irq_out           <= 1'b0;
			sda_out           <= 1'b0;
		end else begin
			parity_error_flag <= next_pe;
			parity_reg        <= next_parity;
			status_reg        <= next_status;
			irq_oe            <= next_pe | (|flt_s2);
			irq_out           <= 1'b0;
			sda_out           <= 1'b0;
		end
	end

	assign config_reg = regs[0];
	assign control1   = regs[1];
	assign control2   = regs[2];
	assign led1_high  = regs[3];
	assign led1_low   = regs[4];
	assign led2_high  = regs[5];
	assign led2_low   = regs[6];
endmodule : icw_config_port
`default_nettype wire

// ### icw_pkg.sv
// Constants for the configuration write port: register map, field layout,
// reset values and frame sizes.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package icw_pkg;
	// ********************************************************************
	// Register addresses and reset values.
	// ********************************************************************
	localparam logic [3:0] ADDR_STATUS  = 4'h0;
	localparam logic [3:0] ADDR_FIRST_WR = 4'h1;
	localparam logic [3:0] ADDR_LAST_WR  = 4'h7;
	localparam logic [3:0] ADDR_PARITY  = 4'h8;
	localparam int         NUM_WR_REGS  = 7;
	localparam logic [7:0] RST_CONFIG   = 8'h80;
	localparam logic [7:0] RST_CTRL1    = 8'h21;
	localparam logic [7:0] RST_CTRL2    = 8'h21;
	localparam logic [7:0] RST_LED      = 8'h00;
	localparam logic [7:0] RST_PARITY   = 8'h00;
	localparam logic [7:0] IDLE_BYTE    = 8'hFF;
	// ********************************************************************
	// Field positions.
	// ********************************************************************
	localparam int ST_PWR      = 7;
	localparam int ST_OVT      = 5;
	localparam int ST_CQOL     = 4;
	localparam int ST_IQOL     = 3;
	localparam int ST_REGLN    = 1;
	localparam int ST_PE       = 0;
	localparam int PAR_STATUS  = 7;
	localparam int CUR_PAR_HI  = 7;
	localparam int CUR_PAR_LO  = 5;
	localparam int CUR_ADDR_HI = 3;
	localparam logic [7:0] ODD_MASK  = 8'hAA;
	localparam logic [7:0] EVEN_MASK = 8'h55;
	// ********************************************************************
	// Frame sizes.
	// ********************************************************************
	localparam logic [3:0] ACK_BIT   = 4'h8;
	localparam logic [3:0] LAST_BIT  = 4'h7;
	localparam logic [3:0] CUR_BYTES = 4'h2;
	localparam logic [3:0] SEQ_BYTES = 4'h8;
	localparam logic [3:0] RD_STATUS = 4'h1;
	localparam logic [3:0] RD_PARITY = 4'h2;
	localparam int         NUM_FAULTS = 5;
endpackage : icw_pkg
`default_nettype wire

// ### icw_config_port_monitor.sv
// Assertion checker for the configuration write port.
// Assumes it is bound to icw_config_port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module icw_config_port_monitor import icw_pkg::*; (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       scl,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       irq_out,
	input wire logic       irq_oe,
	input wire logic       fault_power_on,
	input wire logic       fault_overtemp,
	input wire logic       fault_cq_overload,
	input wire logic       fault_iq_overload,
	input wire logic       fault_reg_undervolt,
	input wire logic [7:0] config_reg,
	input wire logic [7:0] control1,
	input wire logic [7:0] control2,
	input wire logic [7:0] led1_high,
	input wire logic [7:0] led1_low,
	input wire logic [7:0] led2_high,
	input wire logic [7:0] led2_low,
	input wire logic [7:0] parity_reg,
	input wire logic [7:0] status_reg,
	input wire logic       parity_error_flag
);
	// ********************************************************************
	// Port relations.
	// ********************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	wire logic        faults = fault_power_on | fault_overtemp |
		fault_cq_overload | fault_iq_overload | fault_reg_undervolt;
	wire logic [55:0] regs = {config_reg, control1, control2, led1_high,
		led1_low, led2_high, led2_low};
	open_drain_a: assert property (!sda_out && !irq_out)
		else $error("Open-drain output driven high.");
	irq_on_flag_a: assert property ($rose(parity_error_flag) |=> irq_oe)
		else $error("Interrupt missing after parity error.");
	irq_release_a: assert property (
		(!parity_error_flag && !faults)[*5] |-> !irq_oe)
		else $error("Interrupt held without cause.");
	fault_irq_a: assert property (fault_overtemp[*5]
		|-> irq_oe && status_reg[ST_OVT])
		else $error("Fault not reported.");
	flag_status_a: assert property ($rose(parity_error_flag)
		|-> ##[0:3] status_reg[ST_PE])
		else $error("Status error bit not set.");
	regs_commit_a: assert property (!$stable(regs) |-> scl && sda_in)
		else $error("Registers changed inside a frame.");
	flag_commit_a: assert property ($changed(parity_error_flag)
		|-> scl && sda_in)
		else $error("Error flag changed inside a frame.");
	ack_edge_a: assert property ($rose(sda_oe) |-> !scl)
		else $error("Acknowledge began while SCL high.");
	reserved_a: assert property (!status_reg[6] && !status_reg[2])
		else $error("Reserved status bit set.");
	err_c: cover property ($rose(parity_error_flag));
	ack_c: cover property ($rose(sda_oe));
	clear_c: cover property ($fell(parity_error_flag));
endmodule : icw_config_port_monitor
bind icw_config_port icw_config_port_monitor icw_config_port_monitor_inst (.*);
`default_nettype wire

// ### icw_host_model.sv
// I2C master model standing in for the host controller.
// Assumes sda_in is the resolved bus level with a pull-up on SDA.
`timescale 1ns/10ps
`default_nettype none
module icw_host_model #(
	parameter int HALF = 20
) (
	output var logic scl,
	output var logic sda_low,
	input wire logic sda_in
);
	// ********************************************************************
	// Bus cycles; SCL stands high between frames.
	// ********************************************************************
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start_cond;
		sda_low = 1'b1;
		#HALF scl = 1'b0;
		#(HALF/2);
	endtask : start_cond
	task automatic stop_cond;
		sda_low = 1'b1;
		#(HALF/2) scl = 1'b1;
		#HALF sda_low = 1'b0;
		#HALF;
	endtask : stop_cond
	task automatic clk_bit(input logic b, output logic s);
		sda_low = ~b;
		#(HALF/2) scl = 1'b1;
		#(HALF/2) s = sda_in;
		#(HALF/2) scl = 1'b0;
		#(HALF/2);
	endtask : clk_bit
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : wr_byte
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(~mack, s);
	endtask : rd_byte
endmodule : icw_host_model
`default_nettype wire

// ### icw_config_port_tb.sv
// Self-checking testbench for the configuration write port.
// Assumes the host model drives the link and pull-ups hold SDA and IRQ.
`timescale 1ns/10ps
`default_nettype none
module icw_config_port_tb import icw_pkg::*;;
	// ********************************************************************
	// Bench, design and host.
	// ********************************************************************
	localparam logic [6:0] SA = 7'h2A; // Arbitrary slave address.
	logic clock = 1'b0;
	logic reset = 1'b0;
	logic fault_ovt = 1'b0;
	logic [55:0] exp_regs = {RST_CONFIG, RST_CTRL1, RST_CTRL2, {4{RST_LED}}};
	logic [7:0] pr;
	wire logic scl, sda_low, sda_oe, irq_oe, flag;
	wire logic [7:0] cfg, c1, c2, l1h, l1l, l2h, l2l, par, st;
	wire logic sda = ~(sda_low | sda_oe);
	wire logic [55:0] wr_all = {cfg, c1, c2, l1h, l1l, l2h, l2l};
	int n_mismatch = 0;
	int check_count = 0;
	always #2 clock = ~clock;
	icw_config_port #(.SLAVE_ADDR(SA)) icw_config_port_inst (
		.clock(clock), .reset(reset), .scl(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .irq_out(), .irq_oe(irq_oe),
		.fault_power_on(1'b0), .fault_overtemp(fault_ovt),
		.fault_cq_overload(1'b0), .fault_iq_overload(1'b0),
		.fault_reg_undervolt(1'b0), .config_reg(cfg), .control1(c1),
		.control2(c2), .led1_high(l1h), .led1_low(l1l), .led2_high(l2h),
		.led2_low(l2l), .parity_reg(par), .status_reg(st),
		.parity_error_flag(flag));
	icw_host_model icw_host_model_inst (.scl(scl), .sda_low(sda_low),
		.sda_in(sda));
	task automatic chk(input string nm, input logic [55:0] e, g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [2:0] cpar(input logic [7:0] d);
		return {^(d & EVEN_MASK), ^(d & ODD_MASK), ^d};
	endfunction : cpar
	function automatic logic [6:0] spar(input logic [55:0] v);
		for (int j = 0; j < 7; j++) spar[j] = ^v[8*j +: 8];
	endfunction : spar
	task automatic settle;
		repeat (10) @(posedge clock);
		#1;
	endtask : settle
	task automatic xfer_start(input logic rd);
		logic ack;
		icw_host_model_inst.start_cond();
		icw_host_model_inst.wr_byte({SA, rd}, ack);
		chk("address ack", 56'h1, 56'(ack));
	endtask : xfer_start
	task automatic cur_write(input logic [3:0] a, input logic [7:0] d,
		input logic bad);
		logic ack;
		xfer_start(1'b0);
		icw_host_model_inst.wr_byte(d, ack);
		chk("data ack", 56'h1, 56'(ack));
		icw_host_model_inst.wr_byte({cpar(d) ^ {bad, 2'b0}, 1'b1, a}, ack);
		icw_host_model_inst.stop_cond();
		settle();
	endtask : cur_write
	task automatic seq_write(input logic [55:0] v, input logic bad);
		logic ack;
		xfer_start(1'b0);
		for (int j = 6; j >= 0; j--) begin
			icw_host_model_inst.wr_byte(v[8*j +: 8], ack);
		end
		icw_host_model_inst.wr_byte({1'b1, spar(v) ^ 7'(bad)}, ack);
		icw_host_model_inst.stop_cond();
		settle();
	endtask : seq_write
	task automatic read_back(input logic [7:0] est);
		logic [7:0] s;
		xfer_start(1'b1);
		icw_host_model_inst.rd_byte(1'b1, s);
		icw_host_model_inst.rd_byte(1'b0, pr);
		icw_host_model_inst.stop_cond();
		settle();
		chk("status read", 56'(est), 56'(s));
		chk("flag cleared", 56'h0, 56'(flag));
		chk("irq released", 56'h0, 56'(irq_oe));
	endtask : read_back
	task automatic t_current;
		logic [7:0] d;
		for (int a = 1; a <= 7; a++) begin
			d = 8'(8'hA7 + a * 8'h1D);
			exp_regs[8*(7-a) +: 8] = d;
			cur_write(4'(a), d, 1'b0);
			chk("current write", exp_regs, wr_all);
			chk("parity bit", 56'(^d), 56'(par[7-a]));
		end
		cur_write(4'h9, 8'h00, 1'b0);
		chk("unmapped write", exp_regs, wr_all);
	endtask : t_current
	task automatic t_cur_err;
		cur_write(4'h2, 8'h38, 1'b1);
		chk("register kept", exp_regs, wr_all);
		chk("flag set", 56'h1, 56'(flag));
		chk("irq asserted", 56'h1, 56'(irq_oe));
		read_back(8'h01);
		chk("failed parity", 56'h1, 56'(pr[5]));
		exp_regs[47:40] = 8'h38;
		cur_write(4'h2, 8'h38, 1'b0);
		chk("rewrite", exp_regs, wr_all);
	endtask : t_cur_err
	task automatic t_seq(input logic [55:0] v);
		seq_write(v, 1'b1);
		chk("sequential kept", exp_regs, wr_all);
		chk("parity image", 56'(spar(v)), 56'(par[6:0]));
		chk("flag set", 56'h1, 56'(flag));
		read_back(8'h01);
		seq_write(v, 1'b0);
		exp_regs = v;
		chk("sequential", exp_regs, wr_all);
		chk("flag clear", 56'h0, 56'(flag));
	endtask : t_seq
	task automatic t_other;
		logic ack;
		icw_host_model_inst.start_cond();
		icw_host_model_inst.wr_byte({SA ^ 7'h01, 1'b0}, ack);
		icw_host_model_inst.stop_cond();
		settle();
		chk("foreign address", 56'h0, 56'(ack));
		fault_ovt = 1'b1;
		settle();
		chk("fault irq", 56'h1, 56'(irq_oe));
		chk("fault status", 56'h20, 56'(st));
		fault_ovt = 1'b0;
		settle();
		chk("fault gone", 56'h0, 56'(irq_oe));
	endtask : t_other
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		#1 reset = 1'b1;
		repeat (10) @(posedge clock);
		#1 reset = 1'b0;
		settle();
		chk("reset image", exp_regs, wr_all);
		chk("reset parity", 56'(RST_PARITY), 56'(par));
		t_current();
		t_cur_err();
		t_seq(56'h0123_4567_89AB_CD);
		t_other();
		finish_test();
	end
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
endmodule : icw_config_port_tb
`default_nettype wire
